// >>> hw/smbus_indexed_block_config_port.sv
// Serial configuration port with indexed block write and block read of config bytes.
module smbus_indexed_block_config_port (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [1:0] trilevel_bandwidth_select_pin,
  input wire logic warm_reset_n,
  output logic [1:0] pll_mode,
  output logic smbus_active
);
  import smbus_cfg_pkg::*;

  `include "smbus_cfg_defs.svh"

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------

  // Stage that follows an acknowledged byte of a write.
  function automatic stage_t next_stage(input stage_t cur);
    stage_t nxt;
    nxt = STG_DATA;
    unique case (cur)
      STG_ADDR: nxt = STG_INDEX;
      STG_INDEX: nxt = STG_COUNT;
      STG_COUNT: nxt = STG_DATA;
      STG_DATA: nxt = STG_DATA;
    endcase
    return nxt;
  endfunction

  // Contents of a register index; unmapped indices read as zero.
  function automatic logic [7:0] reg_value(input logic [7:0] idx, input logic [1:0] strap,
                                           input logic sw_en, input logic [1:0] sw_md,
                                           input logic [4:0] cnt);
    logic [7:0] val;
    val = 8'h00;
    if (idx == `REG_PLL_MODE_CONTROL) begin
      val[`PMC_READBACK_HI:`PMC_READBACK_LO] = strap;
      val[`PMC_SW_ENABLE] = sw_en;
      val[`PMC_SW_MODE_HI:`PMC_SW_MODE_LO] = sw_md;
      val[`PMC_RSVD0] = `PMC_RSVD0_VAL;
    end else if (idx == `REG_READBACK_COUNT) begin
      val = {3'h0, cnt};
    end
    return val;
  endfunction

  // ----------------------------------------------------------------------------
  // Link domain reset and input synchronisers
  // ----------------------------------------------------------------------------

  logic link_rst_n; // Reset released in step with the link clock.
  logic [3:0] link_sync; // Synchronised clock line, data line and latched mode.
  logic [6:0] sys_sync; // Synchronised pin and link levels in the system domain.
  logic [1:0] strap_latched; // Latched mode pin value, system domain.
  logic link_alive; // Input clock seen running, system domain.

  // Reset enters the link domain asynchronously and leaves it on a clock edge.
  bit_sync #(.WIDTH(1)) u_link_rst (
    .clk(link_clk),
    .rst_n(rst_n),
    .d(1'b1),
    .q(link_rst_n)
  );

  // Bus lines and the latched mode value cross into the link domain.
  bit_sync #(.WIDTH(4)) u_link_sync (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .d({scl_i, sda_i, strap_latched}),
    .q(link_sync)
  );

  wire scl_s = link_sync[3]; // Clock line after synchronisation.
  wire sda_s = link_sync[2]; // Data line after synchronisation.
  wire [1:0] strap_link = link_sync[1:0]; // Latched mode as seen by reads.

  // ----------------------------------------------------------------------------
  // Configuration state, link domain
  // ----------------------------------------------------------------------------

  logic software_bw_select_enable; // Software mode selected.
  logic [1:0] sw_mode; // Software mode bits.
  logic [4:0] readback_count_field; // Count sent ahead of a block read.
  logic alive_toggle; // Flips on every rising link clock edge.

  // Levels handed to the system domain: pin, warm reset and software mode.
  bit_sync #(.WIDTH(7)) u_sys_sync (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d({trilevel_bandwidth_select_pin, warm_reset_n, software_bw_select_enable, sw_mode,
        alive_toggle}),
    .q(sys_sync)
  );

  // Pin latch, warm reset apply and input clock watchdog.
  mode_keeper u_mode_keeper (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .strap_sync(sys_sync[6:5]),
    .warm_reset_n_sync(sys_sync[4]),
    .sw_enable_sync(sys_sync[3]),
    .sw_mode_sync(sys_sync[2:1]),
    .alive_toggle_sync(sys_sync[0]),
    .strap_latched(strap_latched),
    .pll_mode(pll_mode),
    .link_alive(link_alive)
  );

  // ----------------------------------------------------------------------------
  // Bus condition detection
  // ----------------------------------------------------------------------------

  logic scl_q; // Clock line one link cycle ago.
  logic sda_q; // Data line one link cycle ago.

  // Previous samples, taken from the synchronised lines only.
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_q; // Data is sampled here.
  wire scl_fall = ~scl_s & scl_q; // Data is changed here.
  wire start_det = scl_s & scl_q & sda_q & ~sda_s; // Start or repeated start.
  wire stop_det = scl_s & scl_q & ~sda_q & sda_s; // Stop.

  // ----------------------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------------------

  link_state_t state; // Bit level state.
  stage_t stage; // Byte being received.
  logic [2:0] bit_cnt; // Bits of the current byte done.
  logic [7:0] shreg; // Receive and transmit shift register.
  logic [7:0] index; // Register index of the next data byte.
  logic read_dir; // Direction bit of the last address byte received, matched or not.
  logic last_bit; // Eighth transmitted bit has been sampled.
  logic link_oe; // Engine pulls the data line low.

  wire [7:0] rx_byte = {shreg[6:0], sda_s}; // Byte with the bit now sampled.
  wire byte_end = scl_rise & (bit_cnt == 3'h7); // Eighth bit sampled.
  wire addr_miss = (stage == STG_ADDR) & (rx_byte[7:1] != `SMB_SLAVE_ADDR);
  wire [7:0] count_byte = reg_value(`REG_READBACK_COUNT, strap_link,
                                    software_bw_select_enable, sw_mode, readback_count_field);
  wire [7:0] read_byte = reg_value(index, strap_link, software_bw_select_enable, sw_mode,
                                   readback_count_field);
  // A data byte of a write completes and lands at the current index.
  wire wr_fire = (state == ST_RX) & byte_end & (stage == STG_DATA);

  // Start and stop win over any byte in progress; otherwise bits move on clock edges.
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state <= ST_IDLE;
      stage <= STG_ADDR;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      index <= 8'h00;
      read_dir <= 1'b0;
      last_bit <= 1'b0;
      link_oe <= 1'b0;
    end else if (stop_det) begin
      state <= ST_IDLE;
      link_oe <= 1'b0;
    end else if (start_det) begin
      state <= ST_RX;
      stage <= STG_ADDR;
      bit_cnt <= 3'h0;
      link_oe <= 1'b0;
    end else begin
      unique case (state)
        // Waiting for a start; the line stays released.
        ST_IDLE: begin
          state <= ST_IDLE;
        end
        // Shift a received byte and decide whether to acknowledge it.
        ST_RX: begin
          if (scl_rise) begin
            shreg <= rx_byte;
            bit_cnt <= bit_cnt + 3'h1;
            if (byte_end) begin
              state <= addr_miss ? ST_IDLE : ST_ACK_SETUP;
              if (stage == STG_ADDR) begin
                read_dir <= sda_s;
              end
              if (stage == STG_INDEX) begin
                index <= rx_byte;
              end
              if (stage == STG_DATA) begin
                index <= index + 8'h01;
              end
            end
          end
        end
        // Pull the line low for the acknowledge bit.
        ST_ACK_SETUP: begin
          if (scl_fall) begin
            link_oe <= 1'b1;
            state <= ST_ACK;
          end
        end
        // End of acknowledge: a read begins with the count, a write goes on.
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt <= 3'h0;
            if ((stage == STG_ADDR) && read_dir) begin
              shreg <= count_byte;
              link_oe <= ~count_byte[7];
              last_bit <= 1'b0;
              state <= ST_TX;
            end else begin
              link_oe <= 1'b0;
              stage <= next_stage(stage);
              state <= ST_RX;
            end
          end
        end
        // Send a byte most significant bit first, changing data on falling edges.
        ST_TX: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            last_bit <= (bit_cnt == 3'h7);
          end else if (scl_fall) begin
            if (last_bit) begin
              link_oe <= 1'b0;
              state <= ST_RACK;
            end else begin
              shreg <= {shreg[6:0], 1'b0};
              link_oe <= ~shreg[6];
            end
          end
        end
        // Host acknowledge fetches the next register; not-acknowledge ends it.
        ST_RACK: begin
          if (scl_rise) begin
            if (!sda_s) begin
              shreg <= read_byte;
              index <= index + 8'h01;
              state <= ST_TX_LOAD;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        // First bit of the fetched byte goes out on the next falling edge.
        ST_TX_LOAD: begin
          if (scl_fall) begin
            bit_cnt <= 3'h0;
            last_bit <= 1'b0;
            link_oe <= ~shreg[7];
            state <= ST_TX;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------------
  // Writable fields update when their data byte completes; read-only bits ignore writes.
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      software_bw_select_enable <= `PMC_SW_ENABLE_RST;
      sw_mode <= `PMC_SW_MODE_RST;
      readback_count_field <= `READBACK_COUNT_RST;
    end else if (wr_fire) begin
      if (index == `REG_PLL_MODE_CONTROL) begin
        software_bw_select_enable <= rx_byte[`PMC_SW_ENABLE];
        sw_mode <= rx_byte[`PMC_SW_MODE_HI:`PMC_SW_MODE_LO];
      end
      if (index == `REG_READBACK_COUNT) begin
        readback_count_field <= rx_byte[4:0];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Input clock liveness
  // ----------------------------------------------------------------------------
  // The toggle only moves while the input clock runs; the watchdog watches it.
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      alive_toggle <= 1'b0;
    end else begin
      alive_toggle <= ~alive_toggle;
    end
  end

  // ----------------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------------
  // Open drain: the data output is always low and only the enable moves. A stopped
  // input clock freezes the engine, so its drive is cut off by the watchdog.
  assign sda_o = 1'b0;
  assign sda_oe = link_oe & link_alive;
  assign smbus_active = link_alive;

endmodule

// >>> include/smbus_cfg_defs.svh
// Constants for the indexed block configuration port: address, register map, resets and timing.
`ifndef SMBUS_CFG_DEFS_SVH
`define SMBUS_CFG_DEFS_SVH

// ----------------------------------------------------------------------------
// Bus address
// ----------------------------------------------------------------------------
// Seven-bit slave address the port answers to.
`define SMB_SLAVE_ADDR 7'h6c

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
// Mode readback and software mode override byte.
`define REG_PLL_MODE_CONTROL 8'h00
// Number of bytes reported ahead of a block read.
`define REG_READBACK_COUNT 8'h07

// ----------------------------------------------------------------------------
// Field positions of the mode control byte
// ----------------------------------------------------------------------------
`define PMC_READBACK_HI 7
`define PMC_READBACK_LO 6
`define PMC_SW_ENABLE 3
`define PMC_SW_MODE_HI 2
`define PMC_SW_MODE_LO 1
`define PMC_RSVD0 0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PMC_SW_ENABLE_RST 1'h0
`define PMC_SW_MODE_RST 2'h3
`define PMC_RSVD0_VAL 1'h1
`define READBACK_COUNT_RST 5'h08

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
// System clock period in nanoseconds.
`define SYS_CLK_PERIOD_NS 5
// Longest silence of the input clock before the port counts it as stopped.
`define LINK_IDLE_NS 1000
// Same silence in system clock cycles, rounded down.
`define LINK_IDLE_CYC ((`LINK_IDLE_NS) / (`SYS_CLK_PERIOD_NS))
// Cycles after reset release before the mode pin is latched.
`define STRAP_SETTLE_CYC 2'h3

`endif

// >>> include/smbus_cfg_pkg.sv
// Types shared by the configuration port: engine states and transfer stages.
package smbus_cfg_pkg;

  // Bit level state of the serial engine.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK_SETUP,
    ST_ACK,
    ST_TX,
    ST_RACK,
    ST_TX_LOAD
  } link_state_t;

  // Which byte of a transaction is being received.
  typedef enum logic [1:0] {
    STG_ADDR,
    STG_INDEX,
    STG_COUNT,
    STG_DATA
  } stage_t;

endpackage

// >>> hw/bit_sync.sv
// Two flip-flop synchroniser for levels entering a clock domain.
module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // First stage, read only by the second stage.
  logic [WIDTH-1:0] meta;

  // ----------------------------------------------------------------------------
  // Synchroniser stages
  // ----------------------------------------------------------------------------
  // Both stages clear to zero on reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// >>> hw/mode_keeper.sv
// System clock side: mode pin latch, warm reset mode apply and input clock watchdog.
module mode_keeper (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] strap_sync,
  input wire logic warm_reset_n_sync,
  input wire logic sw_enable_sync,
  input wire logic [1:0] sw_mode_sync,
  input wire logic alive_toggle_sync,
  output logic [1:0] strap_latched,
  output logic [1:0] pll_mode,
  output logic link_alive
);
  import smbus_cfg_pkg::*;

  `include "smbus_cfg_defs.svh"

  logic [1:0] settle_cnt; // Cycles waited after reset for the pin sample.
  logic captured; // The mode pin has been latched.
  logic warm_prev; // Last synchronised warm reset level.
  logic toggle_prev; // Last synchronised input clock toggle.
  logic [7:0] idle_cnt; // System cycles since the last input clock toggle.

  // Warm reset assertion is taken on its falling edge.
  wire warm_fall = warm_prev & ~warm_reset_n_sync;
  // The input clock is shown alive by every change of its toggle.
  wire toggle_seen = toggle_prev ^ alive_toggle_sync;
  // Silence limit reached.
  wire idle_limit = (idle_cnt == 8'(`LINK_IDLE_CYC));

  // ----------------------------------------------------------------------------
  // Mode latch and warm reset apply
  // ----------------------------------------------------------------------------
  // The pin is latched once, after the synchroniser has settled, and the
  // software choice only reaches the PLL at a warm reset.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt <= 2'h0;
      captured <= 1'b0;
      strap_latched <= 2'h0;
      pll_mode <= 2'h0;
      warm_prev <= 1'b0;
    end else begin
      warm_prev <= warm_reset_n_sync;
      if (!captured) begin
        if (settle_cnt == `STRAP_SETTLE_CYC) begin
          captured <= 1'b1;
          strap_latched <= strap_sync;
          pll_mode <= strap_sync;
        end else begin
          settle_cnt <= settle_cnt + 2'h1;
        end
      end else if (warm_fall) begin
        pll_mode <= sw_enable_sync ? sw_mode_sync : strap_latched;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Input clock watchdog
  // ----------------------------------------------------------------------------
  // The port is active while the input clock keeps toggling.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      toggle_prev <= 1'b0;
      idle_cnt <= 8'h00;
      link_alive <= 1'b0;
    end else begin
      toggle_prev <= alive_toggle_sync;
      if (toggle_seen) begin
        idle_cnt <= 8'h00;
        link_alive <= 1'b1;
      end else if (idle_limit) begin
        link_alive <= 1'b0;
      end else begin
        idle_cnt <= idle_cnt + 8'h01;
      end
    end
  end

endmodule

// >>> test/smbus_cfg_port_sva.sv
// Assertions and covers watching the pins of the configuration port.
module smbus_cfg_port_sva (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic [1:0] trilevel_bandwidth_select_pin,
  input wire logic warm_reset_n,
  input wire logic [1:0] pll_mode,
  input wire logic smbus_active
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // Helper counters
  // ----
  logic link_q; // Input clock level seen one cycle ago.
  logic [7:0] since_link; // Cycles since the input clock moved.
  logic [7:0] since_warm; // Cycles since warm reset was low.
  logic [7:0] since_rst; // Cycles since cold reset ended.
  // All counters saturate so long runs stay meaningful.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_q <= 1'b0;
      since_link <= 8'h00;
      since_warm <= 8'hff;
      since_rst <= 8'h00;
    end else begin
      link_q <= link_clk;
      since_link <= (link_q != link_clk) ? 8'h00 : since_link + 8'(since_link != 8'hff);
      since_warm <= !warm_reset_n ? 8'h00 : since_warm + 8'(since_warm != 8'hff);
      since_rst <= since_rst + 8'(since_rst != 8'hff);
    end
  end
  // ----
  // Assertions
  // ----
  a_open_drain: assert property (@(posedge sys_clk) disable iff (!rst_n) sda_o == 1'b0)
    else $error("data line driven high");
  a_drive_scl_low: assert property (@(posedge link_clk) disable iff (!rst_n)
    $rose(sda_oe) |-> !scl_i) else $error("drive began with clock high");
  a_release_scl_low: assert property (@(posedge link_clk) disable iff (!rst_n)
    $fell(sda_oe) |-> !scl_i) else $error("release with clock high");
  a_hold_clk_high: assert property (@(posedge link_clk) disable iff (!rst_n)
    scl_i && $past(scl_i) |-> $stable(sda_oe)) else $error("data moved with clock high");
  a_ack_whole_bit: assert property (@(posedge link_clk) disable iff (!rst_n)
    $rose(sda_oe) |-> sda_oe [*6]) else $error("drive too short");
  a_idle_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
    since_link >= 8'd230 |-> !sda_oe && !smbus_active) else $error("active without clock");
  a_active_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
    since_link < 8'd40 && since_rst > 8'd150 |-> smbus_active) else $error("not active");
  a_mode_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) |-> ##8 pll_mode == trilevel_bandwidth_select_pin) else $error("bad latch");
  a_mode_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed(pll_mode) |-> since_warm < 8'd8 || since_rst < 8'd10) else $error("mode moved");
  c_ack: cover property (@(posedge link_clk) disable iff (!rst_n) $rose(sda_oe));
  c_warm: cover property (@(posedge sys_clk) disable iff (!rst_n) $fell(warm_reset_n));
  c_stop: cover property (@(posedge sys_clk) disable iff (!rst_n) $fell(smbus_active));
endmodule

bind smbus_indexed_block_config_port smbus_cfg_port_sva chk_u (.sys_clk, .rst_n, .link_clk,
  .scl_i, .sda_i, .sda_o, .sda_oe, .trilevel_bandwidth_select_pin, .warm_reset_n, .pll_mode,
  .smbus_active);

// >>> test/smbus_host_model.sv
// Behavioural bus host that clocks bytes into and out of the port.
module smbus_host_model (
  input wire logic sda,
  output logic scl,
  output logic pull_low
);
  timeunit 1ns;
  timeprecision 100ps;
  // Quarter bit. The port answers two to three input clock periods after a clock fall,
  // so half a bit (two quarters) leaves room for that delay and keeps the run short.
  localparam int Q = 400;
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
  end
  // One bit: data set mid low phase, line read at the end of the high phase.
  task automatic bit_x(input logic v, output logic s);
    #Q pull_low = ~v;
    #Q scl = 1'b1;
    #(2 * Q) s = sda;
    scl = 1'b0;
  endtask
  // Start from idle, or repeated start from a low clock.
  task automatic start();
    #Q pull_low = 1'b0;
    #Q scl = 1'b1;
    #Q pull_low = 1'b1;
    #Q scl = 1'b0;
  endtask
  // Stop: data rises while the clock is high, bus left idle.
  task automatic stop();
    #Q pull_low = 1'b1;
    #Q scl = 1'b1;
    #Q pull_low = 1'b0;
    #Q;
  endtask
  // Eight bits out or in, then the ninth bit; ack reports a low ninth bit.
  task automatic byte_x(input logic [7:0] tx, input logic nine, output logic [7:0] rx,
                        output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], s);
      rx[i] = s;
    end
    bit_x(nine, s);
    ack = ~s;
  endtask
endmodule

// >>> test/smbus_indexed_block_config_port_tb.sv
// Self-checking bench for the indexed block configuration port.
`include "smbus_cfg_defs.svh"
module smbus_indexed_block_config_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic link_clk = 1'b0;
  logic link_run = 1'b1; // Input clock runs while set.
  logic [1:0] pin = 2'h0;
  logic warm_reset_n = 1'b1;
  logic scl;
  logic pull_low;
  logic sda_o;
  logic sda_oe;
  logic [1:0] pll_mode;
  logic smbus_active;
  wire logic sda_line = ~(pull_low | (sda_oe & ~sda_o)); // Pulled-up open-drain wire.
  logic [1:0] modes [3] = '{2'h0, 2'h1, 2'h3};
  logic [1:0] strap;
  logic [1:0] md;
  logic [1:0] cur;
  logic en;
  logic [7:0] d;
  int si;
  int errors = 0;
  int num_checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  // Input clock with its own phase; it can be stopped.
  initial begin
    #41.3;
    forever #80 link_clk = link_run ? ~link_clk : link_clk;
  end
  smbus_indexed_block_config_port dut_u (.sys_clk, .rst_n, .link_clk, .scl_i(scl),
    .sda_i(sda_line), .sda_o, .sda_oe, .trilevel_bandwidth_select_pin(pin), .warm_reset_n,
    .pll_mode, .smbus_active);
  smbus_host_model host_u (.sda(sda_line), .scl, .pull_low);
  // ----
  // Checking and bus tasks
  // ----
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Expected mode control byte.
  function automatic logic [7:0] b0(input logic [1:0] s, input logic e, input logic [1:0] m);
    return {s, 2'b00, e, m, `PMC_RSVD0_VAL};
  endfunction
  // Host sends a byte and checks the answer on the ninth bit.
  task automatic put(input logic [7:0] b, input logic exp_ack);
    logic [7:0] r;
    logic a;
    host_u.byte_x(b, 1'b1, r, a);
    chk("ack", {7'h00, exp_ack}, {7'h00, a});
  endtask
  // Block write of one byte at an index.
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    host_u.start();
    put({`SMB_SLAVE_ADDR, 1'b0}, 1'b1);
    put(idx, 1'b1);
    put(8'h01, 1'b1);
    put(v, 1'b1);
    host_u.stop();
  endtask
  // Block read from an index: count byte, then two data bytes.
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp_cnt, input logic [7:0] exp_b);
    logic [7:0] r;
    logic a;
    host_u.start();
    put({`SMB_SLAVE_ADDR, 1'b0}, 1'b1);
    put(idx, 1'b1);
    host_u.start();
    put({`SMB_SLAVE_ADDR, 1'b1}, 1'b1);
    host_u.byte_x(8'hff, 1'b0, r, a);
    chk("count", exp_cnt, r);
    for (int k = 0; k < 2; k++) begin
      host_u.byte_x(8'hff, k[0], r, a);
      chk("data", (k == 0) ? exp_b : 8'h00, r);
    end
    host_u.stop();
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    void'($urandom(32'hf28c0232));
    si = $urandom_range(2);
    strap = modes[si];
    pin = strap;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 400 && smbus_active !== 1'b1; i++) @(negedge sys_clk);
    chk("active", 8'h01, {7'h00, smbus_active});
    repeat (400) @(negedge sys_clk);
    chk("mode", {6'h00, strap}, {6'h00, pll_mode});
    pin = modes[(si + 1) % 3];
    rd(8'h00, {3'h0, `READBACK_COUNT_RST}, b0(strap, `PMC_SW_ENABLE_RST, `PMC_SW_MODE_RST));
    $display("test reset values: done");
    host_u.start();
    put({`SMB_SLAVE_ADDR ^ 7'($urandom_range(1, 127)), 1'b0}, 1'b0);
    host_u.stop();
    $display("test foreign address: done");
    cur = strap;
    for (int i = 0; i < 3; i++) begin
      // Pin mode first, then software mode, then a random choice.
      en = (i == 2) ? 1'($urandom) : i[0];
      md = modes[i];
      d = 8'($urandom);
      d[3:1] = {en, md};
      wr(8'h00, d);
      chk("hold", {6'h00, cur}, {6'h00, pll_mode});
      @(negedge sys_clk) warm_reset_n = 1'b0;
      repeat (6) @(negedge sys_clk);
      cur = en ? md : strap;
      chk("apply", {6'h00, cur}, {6'h00, pll_mode});
      warm_reset_n = 1'b1;
      $display("test mode %0d: done", i);
    end
    d = 8'($urandom);
    wr(`REG_READBACK_COUNT, d);
    rd(8'h00, {3'h0, d[4:0]}, b0(strap, en, md));
    $display("test count write: done");
    link_run = 1'b0;
    for (int i = 0; i < 400 && smbus_active !== 1'b0; i++) @(negedge sys_clk);
    chk("idle", 8'h00, {7'h00, smbus_active});
    host_u.start();
    put({`SMB_SLAVE_ADDR, 1'b0}, 1'b0);
    $display("test stopped clock: done");
    summarize();
  end
  // A hung run counts as a mismatch.
  initial begin
    #500us;
    errors++;
    summarize();
  end
endmodule
